// ---- logic/ramp_limit_counter.v ----
// Ramp accumulator bounds, ramp counter, segment controls and their APB register file.
//
// Design decision made here: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "ramp_limit_defs.vh"

module ramp_limit_counter #(
    parameter SEGMENTS = 8
) (
    input wire core_clk,
    input wire rst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire trig1_pin,
    input wire trig2_pin,
    input wire mod_pin,
    input wire lock_detect,
    input wire cmp0_hit,
    input wire cmp1_hit,
    input wire cpg_level,
    input wire flag0_level,
    input wire [2:0] seg_index,
    input wire step_strobe,
    input wire transition_strobe,
    input wire accum_clear,
    input wire [32:0] deviation_offset,
    output reg [32:0] ramp_value,
    output reg [32:0] deviated_value,
    output reg seg_fast_settle,
    output wire trigger_a,
    output wire trigger_b,
    output wire trigger_c,
    output reg ramp_enable,
    output reg tally_done
);

    // Configuration state.
    reg [32:0] floor_bound;
    reg [32:0] ceiling_bound;
    reg [12:0] tally_target;
    reg auto_disarm;
    reg [1:0] tally_step_source;
    reg [3:0] trig_a_source;
    reg [3:0] trig_b_source;
    reg [3:0] trig_c_source;
    reg [29:0] segment_step_value [0:SEGMENTS-1];
    reg segment_fast_settle [0:SEGMENTS-1];

    // Running state.
    reg [12:0] tally_count;
    reg enable_prev;
    reg cpg_prev;
    reg flag0_prev;

    // APB decode state captured in the setup phase.
    reg read_unmapped;

    integer i;

    wire [7:0] reg_idx;
    wire addr_ok;
    wire setup_phase;
    wire write_access;
    wire [3:0] pin_level;
    wire [3:0] pin_rise;
    wire [3:0] pin_fall;
    wire cpg_rise;
    wire cpg_fall;
    wire flag0_rise;
    wire flag0_fall;
    wire count_event;
    wire tally_hit;
    wire seg_write;
    wire [2:0] seg_wr_idx;
    wire signed [33:0] step_ext;
    wire signed [33:0] step_sum;
    wire signed [33:0] floor_ext;
    wire signed [33:0] ceil_ext;

    reg [32:0] next_ramp_value;
    reg [31:0] next_prdata;
    reg next_unmapped;

    // Word-aligned addresses only; anything above the index range is unmapped.
    assign reg_idx = paddr[9:2];
    assign addr_ok = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);
    assign setup_phase = psel && !penable;
    assign write_access = psel && penable && pwrite && addr_ok;

    // Zero wait states; the error flag is computed one cycle early, in the setup phase.
    assign pready = 1'b1;
    assign pslverr = psel && penable && read_unmapped;

    assign seg_write = write_access && (reg_idx >= `IDX_SEG_BASE) && (reg_idx <= `IDX_SEG_LAST);
    assign seg_wr_idx = reg_idx[2:0];

    // External pins are asynchronous and pass two flip-flops before any use.
    pin_sync #(
        .WIDTH(4)
    ) u_pin_sync (
        .core_clk(core_clk),
        .rst(rst),
        .pin({lock_detect, mod_pin, trig2_pin, trig1_pin}),
        .level(pin_level),
        .rise(pin_rise),
        .fall(pin_fall)
    );

    // Segment charge-pump gain and flag come from same-clock ramp logic; only edges are needed.
    always @(posedge core_clk) begin
        if (rst) begin
            cpg_prev <= 1'b0;
            flag0_prev <= 1'b0;
        end else begin
            cpg_prev <= cpg_level;
            flag0_prev <= flag0_level;
        end
    end

    assign cpg_rise = cpg_level && !cpg_prev;
    assign cpg_fall = !cpg_level && cpg_prev;
    assign flag0_rise = flag0_level && !flag0_prev;
    assign flag0_fall = !flag0_level && flag0_prev;

    // Three identical selectors, one per trigger.
    trigger_select u_trig_a (
        .core_clk(core_clk),
        .rst(rst),
        .source(trig_a_source),
        .pin_rise(pin_rise),
        .pin_fall(pin_fall),
        .cmp0_hit(cmp0_hit),
        .cmp1_hit(cmp1_hit),
        .cpg_rise(cpg_rise),
        .cpg_fall(cpg_fall),
        .flag0_rise(flag0_rise),
        .flag0_fall(flag0_fall),
        .trigger(trigger_a)
    );

    trigger_select u_trig_b (
        .core_clk(core_clk),
        .rst(rst),
        .source(trig_b_source),
        .pin_rise(pin_rise),
        .pin_fall(pin_fall),
        .cmp0_hit(cmp0_hit),
        .cmp1_hit(cmp1_hit),
        .cpg_rise(cpg_rise),
        .cpg_fall(cpg_fall),
        .flag0_rise(flag0_rise),
        .flag0_fall(flag0_fall),
        .trigger(trigger_b)
    );

    trigger_select u_trig_c (
        .core_clk(core_clk),
        .rst(rst),
        .source(trig_c_source),
        .pin_rise(pin_rise),
        .pin_fall(pin_fall),
        .cmp0_hit(cmp0_hit),
        .cmp1_hit(cmp1_hit),
        .cpg_rise(cpg_rise),
        .cpg_fall(cpg_fall),
        .flag0_rise(flag0_rise),
        .flag0_fall(flag0_fall),
        .trigger(trigger_c)
    );

    // Count event chosen by the increment source field.
    assign count_event = (tally_step_source == `STEP_SRC_TRANSITION) ? transition_strobe :
                         (tally_step_source == `STEP_SRC_TRIG_A) ? trigger_a :
                         (tally_step_source == `STEP_SRC_TRIG_B) ? trigger_b : trigger_c;

    // Terminal count needs a settled enable, so a count left from the last run never hits.
    assign tally_hit = ramp_enable && enable_prev && (tally_target != 13'h0000) && count_event &&
                       (tally_count == tally_target - 13'h0001);

    // Configuration registers written over APB.
    always @(posedge core_clk) begin
        if (rst) begin
            floor_bound <= `FLOOR_RESET;
            ceiling_bound <= `CEIL_RESET;
            tally_target <= `TALLY_RESET;
            auto_disarm <= 1'b0;
            tally_step_source <= 2'h0;
            trig_a_source <= `TRIG_SRC_RESET;
            trig_b_source <= `TRIG_SRC_RESET;
            trig_c_source <= `TRIG_SRC_RESET;
        end else if (write_access) begin
            case (reg_idx)
                `IDX_TRIG_A: trig_a_source <= pwdata[7:4];
                `IDX_TRIG_BC: begin
                    trig_b_source <= pwdata[3:0];
                    trig_c_source <= pwdata[7:4];
                end
                `IDX_UPPER_BITS: begin
                    floor_bound[32] <= pwdata[`BIT_FLOOR_MSB];
                    ceiling_bound[32] <= pwdata[`BIT_CEIL_MSB];
                end
                8'h4b: floor_bound[7:0] <= pwdata[7:0];
                8'h4c: floor_bound[15:8] <= pwdata[7:0];
                8'h4d: floor_bound[23:16] <= pwdata[7:0];
                `IDX_FLOOR_3: floor_bound[31:24] <= pwdata[7:0];
                `IDX_CEIL_0: ceiling_bound[7:0] <= pwdata[7:0];
                8'h50: ceiling_bound[15:8] <= pwdata[7:0];
                8'h51: ceiling_bound[23:16] <= pwdata[7:0];
                `IDX_CEIL_3: ceiling_bound[31:24] <= pwdata[7:0];
                `IDX_TALLY_LO: tally_target[7:0] <= pwdata[7:0];
                `IDX_TALLY_HI: begin
                    tally_target[12:8] <= pwdata[4:0];
                    auto_disarm <= pwdata[`BIT_AUTO_DISARM];
                    tally_step_source <= pwdata[`LSB_STEP_SRC+1:`LSB_STEP_SRC];
                end
                default: begin
                end
            endcase
        end
    end

    // One independent step and fast-settle bit per segment.
    always @(posedge core_clk) begin
        if (rst) begin
            for (i = 0; i < SEGMENTS; i = i + 1) begin
                segment_step_value[i] <= 30'h00000000;
                segment_fast_settle[i] <= 1'b0;
            end
        end else if (seg_write) begin
            segment_step_value[seg_wr_idx] <= pwdata[29:0];
            segment_fast_settle[seg_wr_idx] <= pwdata[`BIT_SEG_FAST];
        end
    end

    // Ramp enable: a software write wins over an auto-disarm in the same cycle.
    always @(posedge core_clk) begin
        if (rst) begin
            ramp_enable <= 1'b0;
            enable_prev <= 1'b0;
        end else begin
            enable_prev <= ramp_enable;
            if (write_access && (reg_idx == `IDX_CONTROL)) begin
                ramp_enable <= pwdata[`BIT_RAMP_EN];
            end else if (tally_hit && auto_disarm) begin
                ramp_enable <= 1'b0;
            end
        end
    end

    // Ramp tally; it wraps to zero at terminal count so repeated patterns keep counting.
    always @(posedge core_clk) begin
        if (rst) begin
            tally_count <= 13'h0000;
            tally_done <= 1'b0;
        end else begin
            tally_done <= tally_hit;
            if (ramp_enable && !enable_prev) begin
                tally_count <= 13'h0000;
            end else if (tally_hit) begin
                tally_count <= 13'h0000;
            end else if (ramp_enable && (tally_target != 13'h0000) && count_event) begin
                tally_count <= tally_count + 13'h0001;
            end
        end
    end

    // Sign-extend everything to 34 bits so the sum can never overflow before the compare.
    assign step_ext = {{4{segment_step_value[seg_index][29]}}, segment_step_value[seg_index]};
    assign step_sum = $signed({ramp_value[32], ramp_value}) + step_ext;
    assign floor_ext = $signed({floor_bound[32], floor_bound});
    assign ceil_ext = $signed({ceiling_bound[32], ceiling_bound});

    // Saturating step; the ceiling is checked first, so with crossed bounds a sum above the ceiling lands at the ceiling, any other at the floor.
    always @* begin
        next_ramp_value = ramp_value;
        if (accum_clear) begin
            next_ramp_value = 33'h000000000;
        end else if (step_strobe && ramp_enable) begin
            if (step_sum > ceil_ext) begin
                next_ramp_value = ceiling_bound;
            end else if (step_sum < floor_ext) begin
                next_ramp_value = floor_bound;
            end else begin
                next_ramp_value = step_sum[32:0];
            end
        end
    end

    // The deviation is added after the clamp, so the deviated value may leave the bounds.
    always @(posedge core_clk) begin
        if (rst) begin
            ramp_value <= 33'h000000000;
            deviated_value <= 33'h000000000;
            seg_fast_settle <= 1'b0;
        end else begin
            ramp_value <= next_ramp_value;
            deviated_value <= ramp_value + deviation_offset;
            seg_fast_settle <= ramp_enable && segment_fast_settle[seg_index];
        end
    end

    // Read data mux; reserved bits read as zero.
    always @* begin
        next_prdata = 32'h00000000;
        next_unmapped = 1'b0;
        if (!addr_ok) begin
            next_unmapped = 1'b1;
        end else if ((reg_idx >= `IDX_SEG_BASE) && (reg_idx <= `IDX_SEG_LAST)) begin
            next_prdata[29:0] = segment_step_value[reg_idx[2:0]];
            next_prdata[`BIT_SEG_FAST] = segment_fast_settle[reg_idx[2:0]];
        end else begin
            case (reg_idx)
                `IDX_TRIG_A: next_prdata[7:4] = trig_a_source;
                `IDX_TRIG_BC: next_prdata[7:0] = {trig_c_source, trig_b_source};
                `IDX_UPPER_BITS: begin
                    next_prdata[`BIT_FLOOR_MSB] = floor_bound[32];
                    next_prdata[`BIT_CEIL_MSB] = ceiling_bound[32];
                end
                8'h4b: next_prdata[7:0] = floor_bound[7:0];
                8'h4c: next_prdata[7:0] = floor_bound[15:8];
                8'h4d: next_prdata[7:0] = floor_bound[23:16];
                `IDX_FLOOR_3: next_prdata[7:0] = floor_bound[31:24];
                `IDX_CEIL_0: next_prdata[7:0] = ceiling_bound[7:0];
                8'h50: next_prdata[7:0] = ceiling_bound[15:8];
                8'h51: next_prdata[7:0] = ceiling_bound[23:16];
                `IDX_CEIL_3: next_prdata[7:0] = ceiling_bound[31:24];
                `IDX_TALLY_LO: next_prdata[7:0] = tally_target[7:0];
                `IDX_TALLY_HI: next_prdata[7:0] = {tally_step_source, auto_disarm, tally_target[12:8]};
                `IDX_CONTROL: next_prdata[`BIT_RAMP_EN] = ramp_enable;
                `IDX_STATUS: next_prdata[20:0] = {pin_level, trigger_c, trigger_b, trigger_a, seg_fast_settle,
                                                  tally_count};
                default: next_unmapped = 1'b1;
            endcase
        end
    end

    // Read data and the error flag are captured in the setup phase and held through the access.
    always @(posedge core_clk) begin
        if (rst) begin
            prdata <= 32'h00000000;
            read_unmapped <= 1'b0;
        end else if (setup_phase) begin
            prdata <= pwrite ? 32'h00000000 : next_prdata;
            read_unmapped <= next_unmapped;
        end
    end

endmodule

`default_nettype wire

// ---- logic/ramp_limit_defs.vh ----
// Register indices, field positions and reset values for the ramp limit and counter block.
`ifndef RAMP_LIMIT_DEFS_VH
`define RAMP_LIMIT_DEFS_VH

// Register indices; the APB byte address is four times the index.
`define IDX_TRIG_A 8'h3a
`define IDX_TRIG_BC 8'h3b
`define IDX_UPPER_BITS 8'h46
`define IDX_FLOOR_0 8'h4b
`define IDX_FLOOR_3 8'h4e
`define IDX_CEIL_0 8'h4f
`define IDX_CEIL_3 8'h52
`define IDX_TALLY_LO 8'h53
`define IDX_TALLY_HI 8'h54
`define IDX_SEG_BASE 8'h80
`define IDX_SEG_LAST 8'h87
`define IDX_CONTROL 8'h90
`define IDX_STATUS 8'h91

// Field positions.
`define BIT_FLOOR_MSB 3
`define BIT_CEIL_MSB 4
`define BIT_AUTO_DISARM 5
`define LSB_STEP_SRC 6
`define BIT_SEG_FAST 30
`define BIT_RAMP_EN 0

// Reset values.
`define FLOOR_RESET 33'h000000000
`define CEIL_RESET 33'h1ffffffff
`define TALLY_RESET 13'h0000
`define TRIG_SRC_RESET 4'h0

// Trigger source codes.
`define TRIG_NEVER 4'h0
`define TRIG_ALWAYS 4'h8

// Tally increment sources.
`define STEP_SRC_TRANSITION 2'h0
`define STEP_SRC_TRIG_A 2'h1
`define STEP_SRC_TRIG_B 2'h2
`define STEP_SRC_TRIG_C 2'h3

`endif

// ---- logic/pin_sync.v ----
// Two-stage synchroniser with edge detection for a group of pins.
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
    parameter WIDTH = 4
) (
    input wire core_clk,
    input wire rst,
    input wire [WIDTH-1:0] pin,
    output reg [WIDTH-1:0] level,
    output wire [WIDTH-1:0] rise,
    output wire [WIDTH-1:0] fall
);

    reg [WIDTH-1:0] meta;
    reg [WIDTH-1:0] level_prev;

    // The first stage feeds only the second stage, so no logic sees a metastable value.
    always @(posedge core_clk) begin
        if (rst) begin
            meta <= {WIDTH{1'b0}};
            level <= {WIDTH{1'b0}};
            level_prev <= {WIDTH{1'b0}};
        end else begin
            meta <= pin;
            level <= meta;
            level_prev <= level;
        end
    end

    // Edges are taken between the second stage and its delayed copy.
    assign rise = level & ~level_prev;
    assign fall = ~level & level_prev;

endmodule

`default_nettype wire

// ---- logic/trigger_select.v ----
// One trigger source selector: picks an edge, a level or the constant trigger by a 4-bit code.
`timescale 1ns/1ps
`default_nettype none
`include "ramp_limit_defs.vh"

module trigger_select (
    input wire core_clk,
    input wire rst,
    input wire [3:0] source,
    input wire [3:0] pin_rise,
    input wire [3:0] pin_fall,
    input wire cmp0_hit,
    input wire cmp1_hit,
    input wire cpg_rise,
    input wire cpg_fall,
    input wire flag0_rise,
    input wire flag0_fall,
    output reg trigger
);

    reg next_trigger;

    // Codes 1-7 are rising events, 9-15 the falling twins; 5 and 13 are comparator levels.
    always @* begin
        case (source)
            4'h1: next_trigger = pin_rise[0];
            4'h2: next_trigger = pin_rise[1];
            4'h3: next_trigger = pin_rise[2];
            4'h4: next_trigger = pin_rise[3];
            4'h5: next_trigger = cmp0_hit;
            4'h6: next_trigger = cpg_rise;
            4'h7: next_trigger = flag0_rise;
            `TRIG_ALWAYS: next_trigger = 1'b1;
            4'h9: next_trigger = pin_fall[0];
            4'ha: next_trigger = pin_fall[1];
            4'hb: next_trigger = pin_fall[2];
            4'hc: next_trigger = pin_fall[3];
            4'hd: next_trigger = cmp1_hit;
            4'he: next_trigger = cpg_fall;
            4'hf: next_trigger = flag0_fall;
            default: next_trigger = 1'b0;
        endcase
    end

    // Registered so the trigger output is glitch free.
    always @(posedge core_clk) begin
        if (rst) begin
            trigger <= 1'b0;
        end else begin
            trigger <= next_trigger;
        end
    end

endmodule

`default_nettype wire

// ---- bench/ramp_limit_checks_properties.sv ----
// Port-level checks for the ramp limit and counter block.
`timescale 1ns/1ps
`default_nettype none
module ramp_limit_checks (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic step_strobe,
    input wire logic accum_clear,
    input wire logic [32:0] deviation_offset,
    input wire logic [32:0] ramp_value,
    input wire logic [32:0] deviated_value,
    input wire logic seg_fast_settle,
    input wire logic ramp_enable,
    input wire logic tally_done
);
    // One clock domain; the synchronous reset disables every check.
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    a_dev_after_clamp: assert property (!$past(rst) |-> deviated_value == $past(ramp_value) + $past(deviation_offset))
        else $error("deviated value is not clamped value plus offset");
    a_ramp_hold: assert property (!(step_strobe && ramp_enable) && !accum_clear |=> $stable(ramp_value))
        else $error("ramp value moved without an accepted step");
    a_clear_zero: assert property (accum_clear |=> ramp_value == 33'h000000000)
        else $error("accumulator clear did not give zero");
    a_tally_needs_enable: assert property (tally_done |-> $past(ramp_enable) || $past(ramp_enable, 2))
        else $error("tally done while the ramp was disabled");
    a_disarm_cause: assert property (!$past(rst) && $fell(ramp_enable) |->
        ($past(psel) && $past(penable) && $past(pwrite)) or (##[0:1] tally_done))
        else $error("ramp enable fell without write or terminal count");
    a_fast_off: assert property (!ramp_enable ##1 !ramp_enable |-> !seg_fast_settle)
        else $error("fast settle on while ramp disabled");
    a_slverr_access: assert property (pslverr |-> psel && penable)
        else $error("slave error outside an access phase");
    a_write_no_data: assert property (psel && !penable && pwrite |=> prdata == 32'h00000000)
        else $error("read data not zero during a write");
    a_ready_access: assert property (psel && penable |-> pready)
        else $error("access phase without ready");
endmodule
`default_nettype wire

// ---- bench/tb_top.sv ----
// Self-checking bench for the ramp limit and counter block.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic core_clk, rst, psel, penable, pwrite, step_strobe, transition_strobe, accum_clear, last_err;
    logic pready, pslverr, seg_fast_settle, trigger_a, trigger_b, trigger_c, ramp_enable, tally_done;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0] pins;
    logic [2:0] seg_index;
    logic [32:0] deviation_offset, ramp_value, deviated_value;
    integer err_count = 0;
    integer check_count = 0;

    ramp_limit_counter u_dut (.core_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .trig1_pin(pins[0]), .trig2_pin(pins[1]), .mod_pin(pins[2]), .lock_detect(pins[3]),
        .cmp0_hit(pins[4]), .cmp1_hit(pins[5]), .cpg_level(pins[6]), .flag0_level(pins[7]), .seg_index,
        .step_strobe, .transition_strobe, .accum_clear, .deviation_offset, .ramp_value, .deviated_value,
        .seg_fast_settle, .trigger_a, .trigger_b, .trigger_c, .ramp_enable, .tally_done);

    // Core clock, 10 ns period.
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    task automatic results;
        $display("Comparisons %0d, mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [32:0] exp, input logic [32:0] got);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic chk_bit(input string name, input logic exp, input logic got);
        chk(name, {32'h0, exp}, {32'h0, got});
    endtask

    // Samples settled outputs at the falling edge, then realigns to the rising edge.
    task automatic look(input string name, input logic exp, ref logic s);
        @(negedge core_clk);
        chk_bit(name, exp, s);
        @(posedge core_clk);
    endtask

    // Bounded wait for a pulse or level; a miss ends the run.
    task automatic wait_hi(input string name, ref logic s);
        integer n;
        n = 0;
        do begin
            @(negedge core_clk);
            n++;
        end while (s !== 1'b1 && n < 12);
        chk_bit(name, 1'b1, s);
        if (s !== 1'b1) results();
        @(posedge core_clk);
    endtask

    // APB transfer: the request is held until pready is sampled high, then released.
    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd);
        integer n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wd;
        @(posedge core_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) chk_bit("apb ready", 1'b1, pready);
        if (n >= 20) results();
        rd = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // One idle edge, so a following transfer never reassigns psel in the same step.
        @(posedge core_clk);
    endtask

    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        apb(1'b1, {2'b00, idx, 2'b00}, d);
    endtask

    task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
        apb(1'b0, {2'b00, idx, 2'b00}, 32'h0);
        chk($sformatf("reg %h", idx), {1'b0, exp}, {1'b0, rd});
    endtask

    // One step strobe, accepted only while the ramp is enabled; the clamped value is judged after it lands.
    task automatic step(input logic [32:0] exp);
        step_strobe <= 1'b1;
        @(posedge core_clk);
        step_strobe <= 1'b0;
        @(negedge core_clk);
        chk("ramp value", exp, ramp_value);
        @(posedge core_clk);
    endtask

    task automatic fire;
        transition_strobe <= 1'b1;
        @(posedge core_clk);
        transition_strobe <= 1'b0;
    endtask

    task automatic pulse(input integer n);
        repeat (n) begin
            fire();
            @(posedge core_clk);
        end
    endtask

    task automatic t_regs;
        integer i;
        for (i = 0; i < 4; i++) begin
            rdc(8'h4b + i[7:0], 32'h0);
            rdc(8'h4f + i[7:0], 32'hff);
        end
        rdc(8'h46, 32'h10);
        for (i = 0; i < 8; i++) rdc(8'h80 + i[7:0], 32'h0);
        rdc(8'h53, 32'h0);
        rdc(8'h54, 32'h0);
        apb(1'b0, 12'h801, 32'h0);
        chk_bit("unmapped error", 1'b1, last_err);
        chk("unmapped data", 33'h0, {1'b0, rd});
    endtask

    // Floor -16, ceiling 40, up steps of 15 and down steps of 7.
    task automatic t_clamp;
        integer i, e;
        wr(8'h4b, 32'hf0);
        for (i = 1; i < 4; i++) wr(8'h4b + i[7:0], 32'hff);
        wr(8'h4f, 32'h28);
        for (i = 1; i < 4; i++) wr(8'h4f + i[7:0], 32'h0);
        wr(8'h46, 32'h08);
        rdc(8'h46, 32'h08);
        rdc(8'h4b, 32'hf0);
        wr(8'h80, 32'hf);
        wr(8'h81, 32'h3ffffff9);
        seg_index <= 3'h0;
        wr(8'h90, 32'h1);
        step(33'h00000000f);
        step(33'h00000001e);
        step(33'h000000028);
        step(33'h000000028);
        deviation_offset <= 33'h000000064;
        @(posedge core_clk);
        @(negedge core_clk);
        chk("deviated value", 33'h00000008c, deviated_value);
        @(posedge core_clk);
        seg_index <= 3'h1;
        e = 40;
        for (i = 0; i < 9; i++) begin
            e = (e - 7 < -16) ? -16 : e - 7;
            step({e[31], e});
        end
        wr(8'h90, 32'h0);
        step(33'h1fffffff0);
        accum_clear <= 1'b1;
        @(posedge core_clk);
        accum_clear <= 1'b0;
        @(negedge core_clk);
        chk("cleared value", 33'h0, ramp_value);
        @(posedge core_clk);
    endtask

    task automatic t_fast;
        integer i;
        for (i = 0; i < 8; i++) wr(8'h80 + i[7:0], i[0] ? 32'h40000000 : 32'h0);
        wr(8'h90, 32'h1);
        for (i = 0; i < 8; i++) begin
            seg_index <= i[2:0];
            @(posedge core_clk);
            look("fast settle", i[0], seg_fast_settle);
        end
        wr(8'h90, 32'h0);
        look("fast settle off", 1'b0, seg_fast_settle);
    endtask

    // Trigger A from each rising-edge source and the cmp0 level, then the constant code; B and C from one falling edge and the cmp1 level.
    task automatic t_pins;
        integer c;
        for (c = 1; c < 8; c++) begin
            pins <= 8'h00;
            wr(8'h3a, {c[3:0], 4'h0});
            repeat (4) @(posedge core_clk);
            look("trigger idle", 1'b0, trigger_a);
            pins <= 8'h01 << ((c > 5) ? c : c - 1);
            wait_hi("trigger source", trigger_a);
        end
        pins <= 8'h00;
        wr(8'h3a, 32'h80);
        wait_hi("trigger always", trigger_a);
        wr(8'h3b, 32'hd9);
        pins <= 8'h01;
        repeat (4) @(posedge core_clk);
        pins <= 8'h20;
        wait_hi("trigger fall", trigger_b);
        wait_hi("trigger level", trigger_c);
        pins <= 8'h00;
        wr(8'h3b, 32'h0);
        wr(8'h3a, 32'h0);
    endtask

    task automatic t_tally;
        integer s;
        wr(8'h53, 32'h3);
        wr(8'h54, 32'h20);
        wr(8'h90, 32'h1);
        pulse(2);
        look("early done", 1'b0, tally_done);
        fire();
        wait_hi("tally done", tally_done);
        look("auto disarm", 1'b0, ramp_enable);
        wr(8'h90, 32'h1);
        pulse(2);
        wr(8'h90, 32'h0);
        wr(8'h90, 32'h1);
        repeat (2) @(posedge core_clk);
        pulse(2);
        look("count restarted", 1'b0, tally_done);
        fire();
        wait_hi("done after restart", tally_done);
        wr(8'h54, 32'h0);
        wr(8'h90, 32'h1);
        repeat (2) @(posedge core_clk);
        pulse(2);
        fire();
        wait_hi("done without disarm", tally_done);
        look("enable kept", 1'b1, ramp_enable);
        for (s = 1; s < 4; s++) begin
            wr(8'h90, 32'h0);
            wr(8'h3a, (s == 1) ? 32'h80 : 32'h0);
            wr(8'h3b, (s == 2) ? 32'h08 : (s == 3) ? 32'h80 : 32'h0);
            wr(8'h54, {24'h0, s[1:0], 6'h20});
            wr(8'h90, 32'h1);
            wait_hi("trigger count", tally_done);
            look("trigger disarm", 1'b0, ramp_enable);
        end
    endtask

    // Main sequence: inputs quiet, reset for 20 cycles, then each scenario.
    initial begin
        rst = 1'b1;
        {psel, penable, pwrite, step_strobe, transition_strobe, accum_clear} = 6'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        pins = 8'h00;
        seg_index = 3'h0;
        deviation_offset = 33'h0;
        repeat (20) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        t_regs();
        t_clamp();
        t_fast();
        t_pins();
        t_tally();
        results();
    end
endmodule

bind ramp_limit_counter ramp_limit_checks u_checks (.core_clk, .rst, .psel, .penable, .pwrite, .prdata,
    .pready, .pslverr, .step_strobe, .accum_clear, .deviation_offset, .ramp_value, .deviated_value,
    .seg_fast_settle, .ramp_enable, .tally_done);
`default_nettype wire
